/* File: design/fpe_pkg.sv */
// Constants, field positions and the bus state type of the flash program and erase control block.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package fpe_pkg;

    // Register indices; the byte address is four times the index, taken modulo 2**32.
    localparam logic [31:0] IDX_MODE_CTRL  = 32'hFFFF8580;
    localparam logic [31:0] IDX_ERR_STATUS = 32'hFFFF8581;
    localparam logic [31:0] IDX_BLOCK_SEL  = 32'hFFFF8582;
    localparam logic [31:0] IDX_OVERLAY    = 32'hFFFF8628;

    // Field positions of the mode control, error status and overlay registers.
    localparam int BIT_HW_WRITE_ENABLE = 7;
    localparam int BIT_SW_WRITE_ENABLE = 6;
    localparam int BIT_ERASE_SETUP     = 5;
    localparam int BIT_PROGRAM_SETUP   = 4;
    localparam int BIT_ERASE_VERIFY    = 3;
    localparam int BIT_PROGRAM_VERIFY  = 2;
    localparam int BIT_ERASE_START     = 1;
    localparam int BIT_PROGRAM_START   = 0;
    localparam int BIT_FLASH_ERROR     = 7;
    localparam int BIT_OVERLAY_SELECT  = 2;

    // Reset values.
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_OVERLAY  = 16'h0000;

    // Byte lane patterns of the three access sizes.
    localparam logic [3:0] STRB_BYTE = 4'h1;
    localparam logic [3:0] STRB_WORD = 4'h3;
    localparam logic [3:0] STRB_LONG = 4'hF;

    // Access lengths in clock cycles, setup cycle included, and the timer loads derived from them.
    localparam int          CYC_SHORT = 3;
    localparam int          CYC_LONG  = 6;
    localparam logic [2:0]  CNT_SHORT = 3'(CYC_SHORT - 2);
    localparam logic [2:0]  CNT_LONG  = 3'(CYC_LONG - 2);

    // Positions of the synchronised pins.
    localparam int PIN_PROTECT  = 0;
    localparam int PIN_FLASH_EN = 1;
    localparam int PIN_HW_STBY  = 2;
    localparam int PIN_SW_STBY  = 3;

    typedef enum logic [1:0] {
        FPE_IDLE = 2'b00,
        FPE_WAIT = 2'b01,
        FPE_DONE = 2'b11
    } fpe_state_type;

endpackage : fpe_pkg

/* File: design/fpe_wait_if.sv */
// Carries the load request and the expiry pulse between the bus logic and its wait timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface fpe_wait_if;
    logic       load;
    logic [2:0] count;
    logic       done;
    modport ctrl  (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface : fpe_wait_if
`default_nettype wire

/* File: design/fpe_wait_timer.sv */
// Down counter that stretches each bus access to its documented length.
// Assumes the loader raises load for one cycle in the setup cycle of a transfer.
`timescale 1ns/100ps
`default_nettype none
module fpe_wait_timer (
    // Clock and reset.
    input  wire logic    pclk,
    input  wire logic    presetn,
    // Link to the bus logic.
    fpe_wait_if.timer    wt
);

    typedef struct packed {
        logic [2:0] cnt;
    } fpe_timer_state_type;

    fpe_timer_state_type q;
    fpe_timer_state_type next_q;

    always_comb begin
        next_q = q;
        if (wt.load) begin
            next_q.cnt = wt.count;
        end else if (q.cnt != 3'h0) begin
            next_q.cnt = q.cnt - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // The last counted cycle marks the cycle before the answer.
    assign wt.done = (q.cnt == 3'h1);

endmodule : fpe_wait_timer
`default_nettype wire

/* File: design/fpe_ctrl.sv */
// Flash program and erase control registers behind an APB slave port.
// Assumes pins arrive asynchronously and the error event comes from logic on pclk.
//
// Overview of operation
// R1: Hardware write enable bit 7 is read-only and mirrors the protect pin.
// R2: Software write enable can be set only while hardware write enable is 1.
// R3: Setup and verify bit writes act only when both write enables are 1.
// R4: Erase start write acts only with both enables and erase setup set.
// R5: Program start write acts only with both enables and program setup set.
// R6: Software enters program mode by enable, then program setup, then program start.
// R7: Software enters erase mode by enable, then erase setup, then erase start.
// R8: Setting a verify bit enters its verify mode, clearing it leaves.
// R9: Erase start set means erase mode, cleared ends it; program start likewise.
// R10: Software sets each setup, verify or start bit in a write of its own.
// R11: Software sets the software enable before other mode bits or block bits.
// R12: Reset and both standby kinds restore the mode control register.
// R13: With flash disabled mode control and block select read zero, ignore writes.
// R14: Error status is read-only and reads zero with flash disabled.
// R15: The three byte registers take byte accesses only, three cycles each.
// R16: Overlay register takes byte, word, longword; three cycles, longword six.
// R17: Software writes zero to the lower word on an overlay longword write.
// R18: Block select is forced to zero without both write enables.
// R19: A set error flag blocks program and erase; only power-on reset clears it.
// R20: Each set block select bit makes its block erasable; one at a time. Several set bits here enable all their blocks together.
// R21: Overlay select set protects every flash block from program and erase.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fpe_ctrl (
    // Clock and power-on reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins and status from the rest of the chip.
    input  wire logic        prog_protect_pin,
    input  wire logic        flash_enable_pin,
    input  wire logic        hw_standby_pin,
    input  wire logic        sw_standby_pin,
    input  wire logic        flash_error_event,
    // Mode outputs to the flash array.
    output logic             erase_mode,
    output logic             program_mode,
    output logic             erase_verify_mode,
    output logic             program_verify_mode,
    output logic      [7:0]  block_erase_enable,
    output logic             overlay_active,
    output logic      [1:0]  overlay_area
);

    typedef struct packed {
        fpe_pkg::fpe_state_type st;
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [3:0]  filt;
        logic        sw_write_enable;
        logic        erase_setup;
        logic        program_setup;
        logic        erase_verify;
        logic        program_verify;
        logic        erase_start;
        logic        program_start;
        logic        flash_error_flag;
        logic [7:0]  erase_block_select;
        logic        overlay_select;
        logic [1:0]  area;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        m_erase;
        logic        m_program;
        logic        m_ev;
        logic        m_pv;
        logic [7:0]  m_blocks;
        logic        m_overlay;
        logic [1:0]  m_area;
    } fpe_ctrl_state_type;

    fpe_ctrl_state_type q;
    fpe_ctrl_state_type next_q;

    fpe_wait_if wt ();

    fpe_wait_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .wt      (wt.timer)
    );

    logic       hw_write_enable;
    logic       flash_en;
    logic       hit_mode;
    logic       hit_status;
    logic       hit_block;
    logic       hit_overlay;
    logic       is_long;
    logic       bad_access;
    logic       protect;
    logic       next_protect;
    logic [7:0] mode_byte;
    logic [7:0] w;

    assign hw_write_enable = q.filt[fpe_pkg::PIN_PROTECT];
    assign flash_en        = q.filt[fpe_pkg::PIN_FLASH_EN];
    assign hit_mode        = (paddr[31:2] == fpe_pkg::IDX_MODE_CTRL[29:0]);
    assign hit_status      = (paddr[31:2] == fpe_pkg::IDX_ERR_STATUS[29:0]);
    assign hit_block       = (paddr[31:2] == fpe_pkg::IDX_BLOCK_SEL[29:0]);
    assign hit_overlay     = (paddr[31:2] == fpe_pkg::IDX_OVERLAY[29:0]);
    assign is_long         = hit_overlay && pwrite && (pstrb == fpe_pkg::STRB_LONG);
    assign w               = pwdata[7:0];
    assign protect         = q.flash_error_flag || q.overlay_select || !hw_write_enable || !flash_en; // R19 R21
    assign mode_byte       = {hw_write_enable, q.sw_write_enable, q.erase_setup, q.program_setup,
                              q.erase_verify, q.program_verify, q.erase_start, q.program_start}; // R1

    // Unmapped addresses and wrong access sizes answer with an error and change nothing.
    always_comb begin
        bad_access = 1'b1;
        if (hit_mode || hit_status || hit_block) begin
            bad_access = pwrite && (pstrb != fpe_pkg::STRB_BYTE); // R15
        end else if (hit_overlay) begin
            bad_access = pwrite && !(pstrb == fpe_pkg::STRB_BYTE || pstrb == fpe_pkg::STRB_WORD
                                     || pstrb == fpe_pkg::STRB_LONG); // R16
        end
    end

    // The timer is loaded in the setup cycle with the length of the access less two.
    assign wt.load  = (q.st == fpe_pkg::FPE_IDLE) && psel && !penable;
    assign wt.count = is_long ? fpe_pkg::CNT_LONG : fpe_pkg::CNT_SHORT; // R15 R16

    always_comb begin
        next_q = q;

        // Three stage synchronisers; a change counts once the last two stages agree.
        next_q.s1 = {sw_standby_pin, hw_standby_pin, flash_enable_pin, prog_protect_pin};
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        for (int i = 0; i < 4; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                next_q.filt[i] = q.s3[i]; // R1
            end
        end

        // Bus sequencing.
        case (q.st)
            fpe_pkg::FPE_IDLE: begin
                if (psel && !penable) begin
                    next_q.st = fpe_pkg::FPE_WAIT;
                end
            end
            fpe_pkg::FPE_WAIT: begin
                if (wt.done) begin
                    next_q.st    = fpe_pkg::FPE_DONE;
                    next_q.ready = 1'b1;
                    next_q.err   = bad_access;
                    next_q.rdata = 32'h0000_0000;
                    if (!bad_access && !pwrite) begin
                        if (hit_mode && flash_en) begin
                            next_q.rdata[7:0] = mode_byte; // R13
                        end else if (hit_status && flash_en) begin
                            next_q.rdata[fpe_pkg::BIT_FLASH_ERROR] = q.flash_error_flag; // R14
                        end else if (hit_block && flash_en) begin
                            next_q.rdata[7:0] = q.erase_block_select; // R13
                        end else if (hit_overlay) begin
                            next_q.rdata[fpe_pkg::BIT_OVERLAY_SELECT] = q.overlay_select;
                            next_q.rdata[1:0] = q.area;
                        end
                    end
                end
            end
            fpe_pkg::FPE_DONE: begin
                next_q.st    = fpe_pkg::FPE_IDLE;
                next_q.ready = 1'b0;
                next_q.err   = 1'b0;
                if (pwrite && !q.err && flash_en && hit_mode) begin // R13
                    if (hw_write_enable) begin
                        next_q.sw_write_enable = w[fpe_pkg::BIT_SW_WRITE_ENABLE]; // R2
                    end
                    if (hw_write_enable && q.sw_write_enable) begin
                        next_q.erase_setup    = w[fpe_pkg::BIT_ERASE_SETUP]; // R3
                        next_q.program_setup  = w[fpe_pkg::BIT_PROGRAM_SETUP]; // R3
                        next_q.erase_verify   = w[fpe_pkg::BIT_ERASE_VERIFY]; // R3 R8
                        next_q.program_verify = w[fpe_pkg::BIT_PROGRAM_VERIFY]; // R3 R8
                    end
                    if (hw_write_enable && q.sw_write_enable && q.erase_setup) begin
                        next_q.erase_start = w[fpe_pkg::BIT_ERASE_START]; // R4
                    end
                    if (hw_write_enable && q.sw_write_enable && q.program_setup) begin
                        next_q.program_start = w[fpe_pkg::BIT_PROGRAM_START]; // R5
                    end
                end
                if (pwrite && !q.err && flash_en && hit_block && hw_write_enable && q.sw_write_enable) begin
                    next_q.erase_block_select = w; // R20
                end
                if (pwrite && !q.err && hit_overlay) begin
                    next_q.overlay_select = w[fpe_pkg::BIT_OVERLAY_SELECT];
                    next_q.area           = w[1:0];
                end
            end
            default: begin
                next_q.st    = fpe_pkg::FPE_IDLE;
                next_q.ready = 1'b0;
                next_q.err   = 1'b0;
            end
        endcase

        // Block select stays clear without both write enables.
        if (!hw_write_enable || !q.sw_write_enable) begin
            next_q.erase_block_select = fpe_pkg::RST_BYTE; // R18
        end

        // Hardware protection and standby restore the software bits of the mode register.
        if (!hw_write_enable || q.filt[fpe_pkg::PIN_HW_STBY] || q.filt[fpe_pkg::PIN_SW_STBY]) begin
            next_q.sw_write_enable    = 1'b0; // R12
            next_q.erase_setup        = 1'b0;
            next_q.program_setup      = 1'b0;
            next_q.erase_verify       = 1'b0;
            next_q.program_verify     = 1'b0;
            next_q.erase_start        = 1'b0;
            next_q.program_start      = 1'b0;
            next_q.erase_block_select = fpe_pkg::RST_BYTE;
        end
        if (q.filt[fpe_pkg::PIN_HW_STBY]) begin
            next_q.overlay_select = 1'b0;
            next_q.area           = 2'h0;
        end

        // The error flag is sticky; only the power-on reset clears it.
        if (flash_error_event) begin
            next_q.flash_error_flag = 1'b1; // R19
        end

        // Mode outputs follow the state being loaded, so a protecting write blocks program and erase at once.
        next_protect     = next_q.flash_error_flag || next_q.overlay_select
                           || !next_q.filt[fpe_pkg::PIN_PROTECT] || !next_q.filt[fpe_pkg::PIN_FLASH_EN]; // R19 R21
        next_q.m_erase   = next_q.erase_start && !next_protect; // R9 R19 R21
        next_q.m_program = next_q.program_start && !next_protect; // R9 R19 R21
        next_q.m_ev      = next_q.erase_verify && next_q.filt[fpe_pkg::PIN_FLASH_EN]; // R8
        next_q.m_pv      = next_q.program_verify && next_q.filt[fpe_pkg::PIN_FLASH_EN]; // R8
        next_q.m_blocks  = next_protect ? 8'h00 : next_q.erase_block_select; // R20 R21
        next_q.m_overlay = next_q.overlay_select;
        next_q.m_area    = next_q.area;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign prdata              = q.rdata;
    assign pready              = q.ready;
    assign pslverr             = q.err;
    assign erase_mode          = q.m_erase;
    assign program_mode        = q.m_program;
    assign erase_verify_mode   = q.m_ev;
    assign program_verify_mode = q.m_pv;
    assign block_erase_enable  = q.m_blocks;
    assign overlay_active      = q.m_overlay;
    assign overlay_area        = q.m_area;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_hwe_mirror;
        (q.s2[0] == q.s3[0]) |=> (hw_write_enable == $past(q.s3[0]));
    endproperty
    a_hwe_mirror: assert property (p_hwe_mirror) else $error("Hardware enable does not follow the pin."); // R1

    property p_swe_gate;
        $rose(q.sw_write_enable) |-> $past(hw_write_enable);
    endproperty
    a_swe_gate: assert property (p_swe_gate) else $error("Software enable set without hardware enable."); // R2

    property p_setup_gate;
        ($rose(q.erase_setup) || $rose(q.program_setup) || $rose(q.erase_verify) || $rose(q.program_verify))
            |-> $past(hw_write_enable && q.sw_write_enable);
    endproperty
    a_setup_gate: assert property (p_setup_gate) else $error("Setup or verify bit set without enables."); // R3

    property p_erase_gate;
        $rose(q.erase_start) |-> $past(hw_write_enable && q.sw_write_enable && q.erase_setup);
    endproperty
    a_erase_gate: assert property (p_erase_gate) else $error("Erase start set without erase setup."); // R4

    property p_prog_gate;
        $rose(q.program_start) |-> $past(hw_write_enable && q.sw_write_enable && q.program_setup);
    endproperty
    a_prog_gate: assert property (p_prog_gate) else $error("Program start set without program setup."); // R5

    property p_standby;
        q.filt[fpe_pkg::PIN_SW_STBY] |=> (mode_byte[6:0] == 7'h00) && (q.erase_block_select == 8'h00);
    endproperty
    a_standby: assert property (p_standby) else $error("Standby left mode bits set."); // R12

    property p_disabled_read;
        (pready && !pwrite && !$past(flash_en) && (hit_mode || hit_status || hit_block)) |-> (prdata == 32'h0);
    endproperty
    a_disabled_read: assert property (p_disabled_read) else $error("Disabled flash read not zero."); // R13

    property p_short_len;
        (psel && !penable && !is_long && q.st == fpe_pkg::FPE_IDLE) |=> !pready ##1 pready;
    endproperty
    a_short_len: assert property (p_short_len) else $error("Short access not three cycles."); // R15

    property p_long_len;
        (psel && !penable && is_long && q.st == fpe_pkg::FPE_IDLE) |=> !pready [*4] ##1 pready;
    endproperty
    a_long_len: assert property (p_long_len) else $error("Longword access not six cycles."); // R16

    property p_block_forced;
        (!hw_write_enable || !q.sw_write_enable) |=> (q.erase_block_select == 8'h00);
    endproperty
    a_block_forced: assert property (p_block_forced) else $error("Block select not forced clear."); // R18

    property p_error_blocks;
        q.flash_error_flag |=> q.flash_error_flag && !erase_mode && !program_mode && (block_erase_enable == 8'h00);
    endproperty
    a_error_blocks: assert property (p_error_blocks) else $error("Error flag lost or not blocking."); // R19

    property p_overlay_blocks;
        q.overlay_select |-> !erase_mode && !program_mode;
    endproperty
    a_overlay_blocks: assert property (p_overlay_blocks) else $error("Overlay select did not protect."); // R21

    property p_erase_mode;
        (q.erase_start && !protect) |-> erase_mode;
    endproperty
    a_erase_mode: assert property (p_erase_mode) else $error("Erase mode not shown."); // R9

    c_erase: cover property ($rose(erase_mode));
    c_program: cover property ($rose(program_mode));
    c_long: cover property (pready && is_long);
    c_err: cover property (pready && pslverr);

endmodule : fpe_ctrl
`default_nettype wire

/* File: verif/fpe_apb_master.sv */
// Bus master model standing in for software on the peripheral bus.
// Assumes one clock and a slave that answers each access with a pready pulse.
`timescale 1ns/100ps
`default_nettype none
module fpe_apb_master (
    // Clock.
    input  wire logic        pclk,
    // APB master side.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 32'h00000000;
        pwdata  = 32'h00000000;
        pstrb   = 4'h0;
    end
    // One transfer; the request stands until pready is seen at a rising edge.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic er, output int cyc);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        cyc = 1;
        do begin
            @(posedge pclk);
            cyc++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : xfer
endmodule : fpe_apb_master
`default_nettype wire

/* File: verif/fpe_ctrl_test.sv */
// Self-checking bench of the flash program and erase control registers.
// Assumes the bus master model and pins that settle within five clock edges.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module fpe_ctrl_test;
    localparam logic [31:0] M = fpe_pkg::IDX_MODE_CTRL;
    localparam logic [31:0] S = fpe_pkg::IDX_ERR_STATUS;
    localparam logic [31:0] B = fpe_pkg::IDX_BLOCK_SEL;
    localparam logic [31:0] O = fpe_pkg::IDX_OVERLAY;
    localparam int          P_PROT = 0;
    localparam int          P_FEN  = 1;
    localparam int          P_HSB  = 2;
    localparam int          P_SSB  = 3;
    localparam int          P_ERR  = 4;
    logic        pclk;
    logic        presetn;
    logic [4:0]  pins;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic        em, pm, evm, pvm, ov_act, last_err;
    logic [7:0]  blk;
    logic [1:0]  ov_area;
    int          last_cyc, n_errors, n_checks, cycles;

    fpe_apb_master bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fpe_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_protect_pin(pins[P_PROT]), .flash_enable_pin(pins[P_FEN]),
        .hw_standby_pin(pins[P_HSB]), .sw_standby_pin(pins[P_SSB]), .flash_error_event(pins[P_ERR]),
        .erase_mode(em), .program_mode(pm), .erase_verify_mode(evm), .program_verify_mode(pvm),
        .block_erase_enable(blk), .overlay_active(ov_act), .overlay_area(ov_area));

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] adr(input logic [31:0] idx);
        return {idx[29:0], 2'b00};
    endfunction : adr
    task automatic wr(input logic [31:0] idx, input logic [31:0] d, input logic [3:0] s);
        bus.xfer(1'b1, adr(idx), d, s, rdata, last_err, last_cyc);
        @(negedge pclk);
    endtask : wr
    task automatic rdc(input logic [31:0] idx, input logic [31:0] e);
        bus.xfer(1'b0, adr(idx), 32'h00000000, 4'h0, rdata, last_err, last_cyc);
        `CHK("read data", e, rdata);
    endtask : rdc
    task automatic setp(input int b, input logic v);
        @(posedge pclk);
        pins[b] <= v;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
    endtask : setp
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic t_modes;
        wr(M, 32'h40, 4'h1);
        rdc(M, 32'h00);
        setp(P_PROT, 1'b1);
        rdc(M, 32'h80);
        wr(M, 32'h10, 4'h1);
        wr(B, 32'h01, 4'h1);
        rdc(M, 32'h80);
        rdc(B, 32'h00);
        wr(M, 32'hC0, 4'h1);
        wr(M, 32'hC2, 4'h1);
        rdc(M, 32'hC0);
        wr(M, 32'hC1, 4'h1);
        rdc(M, 32'hC0);
        wr(M, 32'hD0, 4'h1);
        wr(M, 32'hD1, 4'h1);
        `CHK("program mode", 1'b1, pm);
        wr(O, 32'h04, 4'h1);
        `CHK("program mode", 1'b0, pm);
        wr(O, 32'h00, 4'h1);
        wr(M, 32'hD0, 4'h1);
        `CHK("program mode", 1'b0, pm);
        wr(M, 32'hC0, 4'h1);
        wr(M, 32'hE0, 4'h1);
        wr(M, 32'hE2, 4'h1);
        `CHK("erase mode", 1'b1, em);
        wr(M, 32'hE0, 4'h1);
        `CHK("erase mode", 1'b0, em);
        wr(M, 32'hC8, 4'h1);
        `CHK("erase verify", 1'b1, evm);
        wr(M, 32'hC4, 4'h1);
        `CHK("program verify", 2'b01, {evm, pvm});
        wr(M, 32'hC0, 4'h1);
        wr(B, 32'h10, 4'h1);
        `CHK("block enable", 8'h10, blk);
        setp(P_PROT, 1'b0);
        rdc(B, 32'h00);
        rdc(M, 32'h00);
        setp(P_PROT, 1'b1);
        $display("test modes done");
    endtask : t_modes

    task automatic t_bus;
        rdc(S, 32'h00);
        `CHK("cycles", 3, last_cyc);
        wr(O, 32'h00000007, 4'hF);
        `CHK("cycles", 6, last_cyc);
        `CHK("overlay", 3'h7, {ov_act, ov_area});
        wr(O, 32'h00000002, 4'h3);
        `CHK("cycles", 3, last_cyc);
        rdc(O, 32'h00000002);
        wr(M, 32'h000000C0, 4'hF);
        `CHK("error", 1'b1, last_err);
        rdc(M, 32'h80);
        wr(32'h00000000, 32'h0, 4'h1);
        `CHK("error", 1'b1, last_err);
        wr(S, 32'hFF, 4'h1);
        rdc(S, 32'h00);
        $display("test bus done");
    endtask : t_bus

    task automatic t_power;
        setp(P_FEN, 1'b0);
        rdc(M, 32'h00);
        wr(M, 32'hC0, 4'h1);
        setp(P_FEN, 1'b1);
        rdc(M, 32'h80);
        wr(M, 32'hC0, 4'h1);
        setp(P_SSB, 1'b1);
        setp(P_SSB, 1'b0);
        rdc(M, 32'h80);
        rdc(O, 32'h02);
        wr(M, 32'hC0, 4'h1);
        setp(P_HSB, 1'b1);
        setp(P_HSB, 1'b0);
        rdc(M, 32'h80);
        rdc(O, 32'h00);
        wr(M, 32'hC0, 4'h1);
        wr(M, 32'hD0, 4'h1);
        setp(P_ERR, 1'b1);
        setp(P_ERR, 1'b0);
        wr(M, 32'hD1, 4'h1);
        rdc(S, 32'h80);
        `CHK("program mode", 1'b0, pm);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        rdc(S, 32'h00);
        rdc(M, 32'h80);
        $display("test power done");
    endtask : t_power

    initial begin
        presetn = 1'b0;
        pins    = 5'b00010;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        t_modes();
        t_bus();
        t_power();
        report_and_stop();
    end
endmodule : fpe_ctrl_test
`undef CHK
`default_nettype wire
